// *** rtl/sdc_pkg.sv ***
// constants and types for the radio core deep sleep controller
package sdc_pkg;
    // register byte addresses
    localparam logic [31:0] A_RXPTR = 32'h4000_002C;
    localparam logic [31:0] A_DSCTL = 32'h4000_0030;
    localparam logic [31:0] A_STIME = 32'h4000_0034;
    localparam logic [31:0] A_SDUR = 32'h4000_0038;
    localparam logic [31:0] A_WTIM = 32'h4000_003C;
    localparam logic [31:0] A_ISTAT = 32'h4000_0070;
    localparam logic [31:0] A_ICLR = 32'h4000_0074;
    localparam logic [31:0] A_IEN = 32'h4000_0078;
    localparam logic [31:0] A_SAMP = 32'h4000_007C;
    localparam logic [31:0] A_SLOT = 32'h4000_0080;
    // control register field positions
    localparam int B_EXT_BLOCK = 31;
    localparam int B_STAT = 15;
    localparam int B_SWAKE = 4;
    localparam int B_RESUME = 3;
    localparam int B_DSON = 2;
    localparam int B_SAMPLE = 0;
    localparam logic [1:0] IRQ_EN_ALL = 2'h3;
    localparam int RXPTR_W = 14;
    localparam int SLOT_W = 27;
    localparam int EV_W = 3;
    localparam int EV_ENTER = 0;
    localparam int EV_WAKE = 1;
    localparam int EV_WIRQ = 2;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    // slot timing
    localparam int SLOT_TIME_NS = 625000;
    localparam int CLK_PERIOD_NS = 40;
    localparam int SLOT_CYC_DEF = SLOT_TIME_NS / CLK_PERIOD_NS;
    localparam int PRE_W = 16;

    typedef enum logic [1:0] {
        ST_ACTIVE = 2'b00,
        ST_ENTER = 2'b01,
        ST_SLEEP = 2'b11,
        ST_EXTWAKE = 2'b10
    } sdc_state_t;

    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
        logic hready;
    } sdc_ahb_req_t;

    typedef struct packed {
        logic [10:0] hold;
        logic [10:0] lead_on;
        logic [9:0] lead_off;
    } sdc_wtim_t;
endpackage

// *** rtl/sdc_deep_sleep_ctrl.sv ***
// deep sleep controller: ahb-lite registers, sleep timer, wake interrupt, slot counter
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ps
module sdc_deep_sleep_ctrl #(
    parameter int SLOT_CYCLES = sdc_pkg::SLOT_CYC_DEF
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire sdc_pkg::sdc_ahb_req_t i_ahb,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    input wire logic i_lp_clk,
    input wire logic i_system_wake_request,
    output logic o_lp_clk_select,
    output logic o_low_power_wake_interrupt,
    output logic o_irq,
    output logic [13:0] o_rx_chain_head,
    output logic [26:0] o_slot_counter_value,
    output logic o_counters_running
);
    import sdc_pkg::*;

    function automatic logic hit(input logic [31:0] a, input logic [31:0] r);
        return a == r;
    endfunction

    // bus phase state
    logic [31:0] ph_addr_r;
    logic ph_wr_r;
    logic ph_rd_r;
    logic [31:0] hrdata_r;
    // registers
    logic [RXPTR_W-1:0] rxptr_r;
    logic ext_block_r;
    logic ds_on_r;
    logic [1:0] irq_en_r;
    logic [31:0] stime_r;
    logic [31:0] dur_r;
    sdc_wtim_t wtim_r;
    logic [EV_W-1:0] istat_r;
    logic [EV_W-1:0] ien_r;
    logic run_r;
    logic [PRE_W-1:0] pre_r;
    logic [SLOT_W-1:0] slot_r;
    logic [SLOT_W-1:0] slot_copy_r;
    logic [10:0] hold_cnt_r;
    logic wirq_r;
    sdc_state_t st_r;
    sdc_state_t st_nxt;
    // low power clock sampling
    logic lp_s1_r;
    logic lp_s2_r;
    logic lp_s3_r;

    // address phase accept and write strobes for the data phase
    wire accept = i_ahb.hsel && i_ahb.htrans[1] && i_ahb.hready;
    wire [31:0] wd = i_ahb.hwdata;
    wire w_rxptr = ph_wr_r && hit(ph_addr_r, A_RXPTR);
    wire w_dsctl = ph_wr_r && hit(ph_addr_r, A_DSCTL);
    wire w_stime = ph_wr_r && hit(ph_addr_r, A_STIME);
    wire w_wtim = ph_wr_r && hit(ph_addr_r, A_WTIM);
    wire w_iclr = ph_wr_r && hit(ph_addr_r, A_ICLR);
    wire w_ien = ph_wr_r && hit(ph_addr_r, A_IEN);
    wire w_samp = ph_wr_r && hit(ph_addr_r, A_SAMP);

    // sleep sequencing terms
    wire lp_tick = lp_s2_r && !lp_s3_r;
    wire sleep_stat = (st_r == ST_SLEEP) || (st_r == ST_EXTWAKE);
    wire timed = stime_r != 32'h0000_0000;
    wire irq_ok = irq_en_r == IRQ_EN_ALL;
    wire [31:0] dur_inc = dur_r + 32'h0000_0001;
    wire [31:0] rem_after = stime_r - dur_inc;
    wire enter_now = (st_r == ST_ENTER) && lp_tick;
    wire wake_tmr = sleep_stat && lp_tick && timed && (dur_inc == stime_r);
    wire soft_go = w_dsctl && wd[B_SWAKE] && sleep_stat;
    wire ext_go = (st_r == ST_SLEEP) && i_system_wake_request && !ext_block_r;
    wire [11:0] hold_next = {1'b0, hold_cnt_r} + 12'h001;
    wire hold_done = (st_r == ST_EXTWAKE) && lp_tick && (hold_next >= {1'b0, wtim_r.hold});
    wire wake_now = soft_go || wake_tmr || hold_done;
    // wake interrupt edges, timer path and external path
    wire lead_on_hit = (st_r == ST_SLEEP) && lp_tick && timed
        && (rem_after == {21'h00_0000, wtim_r.lead_on});
    wire lead_off_hit = sleep_stat && lp_tick && timed
        && (rem_after == {22'h00_0000, wtim_r.lead_off});
    wire wirq_set = irq_ok && (lead_on_hit || (ext_go && !wake_now));
    wire wirq_clr = lead_off_hit || hold_done;
    wire [EV_W-1:0] ev = {wirq_set && !wirq_r, sleep_stat && wake_now, enter_now};

    // readback words
    wire [31:0] dsctl_word = {ext_block_r, 15'h0000, sleep_stat, 10'h000, 2'h0,
        ds_on_r, irq_en_r};
    wire [31:0] rd_word =
        hit(ph_addr_r, A_RXPTR) ? {18'h0_0000, rxptr_r} :
        hit(ph_addr_r, A_DSCTL) ? dsctl_word :
        hit(ph_addr_r, A_STIME) ? stime_r :
        hit(ph_addr_r, A_SDUR) ? dur_r :
        hit(ph_addr_r, A_WTIM) ? wtim_r :
        hit(ph_addr_r, A_ISTAT) ? {29'h0000_0000, istat_r} :
        hit(ph_addr_r, A_IEN) ? {29'h0000_0000, ien_r} :
        hit(ph_addr_r, A_SLOT) ? {5'h00, slot_copy_r} : RST_WORD;

    // outputs; reads take one wait state so a read right after a write sees it
    assign o_hreadyout = !ph_rd_r;
    assign o_hresp = 1'b0;
    assign o_hrdata = hrdata_r;
    assign o_lp_clk_select = sleep_stat;
    assign o_low_power_wake_interrupt = wirq_r;
    assign o_irq = |(istat_r & ien_r);
    assign o_rx_chain_head = rxptr_r;
    assign o_slot_counter_value = slot_r;
    assign o_counters_running = run_r;

    // bus phase tracking
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            ph_addr_r <= RST_WORD;
            ph_wr_r <= 1'b0;
            ph_rd_r <= 1'b0;
        end
        else
        begin
            ph_wr_r <= accept && i_ahb.hwrite;
            ph_rd_r <= accept && !i_ahb.hwrite;
            if (accept)
                ph_addr_r <= i_ahb.haddr;
        end
    end

    // read data is latched in the wait cycle and held until the next read
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
            hrdata_r <= RST_WORD;
        else if (ph_rd_r)
            hrdata_r <= rd_word;
    end

    // plain software registers
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            rxptr_r <= '0;
            ext_block_r <= 1'b0;
            irq_en_r <= 2'h0;
            stime_r <= RST_WORD;
            wtim_r <= RST_WORD;
            ien_r <= '0;
        end
        else
        begin
            if (w_rxptr)
                rxptr_r <= wd[RXPTR_W-1:0];
            if (w_dsctl)
            begin
                ext_block_r <= wd[B_EXT_BLOCK];
                irq_en_r <= wd[1:0];
            end
            if (w_stime)
                stime_r <= wd;
            if (w_wtim)
                wtim_r <= wd;
            if (w_ien)
                ien_r <= wd[EV_W-1:0];
        end
    end

    // sleep request: the wake clears it even against a write in the same cycle,
    // else a software wake written with the request bit still set would re-enter sleep
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
            ds_on_r <= 1'b0;
        else if (sleep_stat && wake_now)
            ds_on_r <= 1'b0;
        else if (w_dsctl)
            ds_on_r <= wd[B_DSON];
    end

    // low power clock sampled on the system clock; three flops for an edge
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            lp_s1_r <= 1'b0;
            lp_s2_r <= 1'b0;
            lp_s3_r <= 1'b0;
        end
        else
        begin
            lp_s1_r <= i_lp_clk;
            lp_s2_r <= lp_s1_r;
            lp_s3_r <= lp_s2_r;
        end
    end

    // sleep state machine; the mux switches in on a low power edge, a software wake switches it back at once
    always_comb
    begin
        st_nxt = st_r;
        case (st_r)
            ST_ACTIVE:
                if (ds_on_r)
                    st_nxt = ST_ENTER;
            ST_ENTER:
                if (!ds_on_r)
                    st_nxt = ST_ACTIVE;
                else if (lp_tick)
                    st_nxt = ST_SLEEP;
            ST_SLEEP:
                if (wake_now)
                    st_nxt = ST_ACTIVE;
                else if (ext_go)
                    st_nxt = ST_EXTWAKE;
            ST_EXTWAKE:
                if (wake_now)
                    st_nxt = ST_ACTIVE;
            default:
                st_nxt = ST_ACTIVE;
        endcase
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
            st_r <= ST_ACTIVE;
        else
            st_r <= st_nxt;
    end

    // measured duration, also the timer's elapsed count
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
            dur_r <= RST_WORD;
        else if (enter_now)
            dur_r <= RST_WORD;
        else if (sleep_stat && lp_tick)
            dur_r <= dur_inc;
    end

    // external wake hold counter, runs only while waiting to release
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst || st_r != ST_EXTWAKE)
            hold_cnt_r <= 11'h000;
        else if (lp_tick)
            hold_cnt_r <= hold_next[10:0];
    end

    // wake interrupt level; a set in the same cycle as a clear wins
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
            wirq_r <= 1'b0;
        else if (wirq_set)
            wirq_r <= 1'b1;
        else if (wirq_clr)
            wirq_r <= 1'b0;
    end

    // sticky event status; new events win over a clear
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
            istat_r <= '0;
        else
            istat_r <= (istat_r & ~(w_iclr ? wd[EV_W-1:0] : '0)) | ev;
    end

    // counters stop on sleep entry and stay stopped until software resumes them
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
            run_r <= 1'b1;
        else if (enter_now)
            run_r <= 1'b0;
        else if (w_dsctl && wd[B_RESUME] && !sleep_stat)
            run_r <= 1'b1;
    end

    // slot prescaler and slot counter; correction values are not applied here
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            pre_r <= '0;
            slot_r <= '0;
        end
        else if (run_r)
        begin
            if (pre_r == PRE_W'(SLOT_CYCLES - 1))
            begin
                pre_r <= '0;
                slot_r <= slot_r + 27'h000_0001;
            end
            else
                pre_r <= pre_r + 16'h0001;
        end
    end

    // readable slot copy is refreshed only by the sample command
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
            slot_copy_r <= '0;
        else if (w_samp && wd[B_SAMPLE])
            slot_copy_r <= slot_r;
    end

    // checks
    default clocking dcb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);

    sequence lead_hit_s;
        lead_on_hit && irq_ok;
    endsequence

    sequence ext_start_s;
        ext_go && irq_ok && !wake_now;
    endsequence

    ptr_write_a: assert property (w_rxptr |=> rxptr_r == $past(wd[13:0]))
        else $error("rx chain head not written");
    ext_block_a: assert property ((st_r == ST_SLEEP && ext_block_r && !wake_now)
        |=> st_r != ST_EXTWAKE)
        else $error("blocked external wake was taken");
    stat_rise_a: assert property ($rose(o_lp_clk_select)
        |-> $past(st_r) == ST_ENTER && $past(lp_tick))
        else $error("sleep status rose without mux switch");
    soft_wake_a: assert property (soft_go |=> !o_lp_clk_select)
        else $error("software wake ignored");
    resume_run_a: assert property ((w_dsctl && wd[B_RESUME] && !sleep_stat)
        |=> o_counters_running)
        else $error("counters not resumed");
    dson_clear_a: assert property ($fell(o_lp_clk_select)
        |-> !ds_on_r)
        else $error("sleep request not cleared on wake");
    timer_wake_a: assert property (wake_tmr |=> !o_lp_clk_select ##1 st_r != ST_SLEEP)
        else $error("timer expiry did not wake");
    inf_sleep_a: assert property ((st_r == ST_SLEEP && !timed && !soft_go && !ext_go)
        |=> st_r == ST_SLEEP)
        else $error("zero sleep time left sleep");
    dur_zero_a: assert property ($rose(o_lp_clk_select) |-> dur_r == 32'h0000_0000)
        else $error("duration not cleared at sleep start");
    dur_step_a: assert property ((sleep_stat && lp_tick)
        |=> dur_r == $past(dur_r) + 32'h0000_0001)
        else $error("duration did not count");
    ext_hold_a: assert property (ext_start_s |=> o_low_power_wake_interrupt
        && st_r == ST_EXTWAKE)
        else $error("external wake interrupt missing");
    irq_lead_a: assert property (lead_hit_s |=> o_low_power_wake_interrupt)
        else $error("wake interrupt not raised at lead");
    irq_release_a: assert property ((lead_off_hit && !wirq_set)
        |=> !o_low_power_wake_interrupt)
        else $error("wake interrupt not released at lead");
    slot_samp_a: assert property ((w_samp && wd[B_SAMPLE])
        |=> slot_copy_r == $past(slot_r))
        else $error("slot copy not sampled");
endmodule // sdc_deep_sleep_ctrl

// *** bench/sdc_deep_sleep_ctrl_test.sv ***
// self-checking testbench for the deep sleep controller
`timescale 1ns/1ps
module sdc_deep_sleep_ctrl_test;
    import sdc_pkg::*;
    logic i_clk_sys = 1'b0;
    logic i_rst = 1'b1;
    logic i_lp_clk = 1'b0;
    logic i_system_wake_request = 1'b0;
    sdc_ahb_req_t drv = '0;
    sdc_ahb_req_t bus;
    logic [31:0] o_hrdata;
    logic o_hreadyout;
    logic o_hresp;
    logic o_lp_clk_select;
    logic o_low_power_wake_interrupt;
    logic o_irq;
    logic o_counters_running;
    logic [13:0] o_rx_chain_head;
    logic [26:0] o_slot_counter_value;
    logic [31:0] rd;
    logic [1:0] lp_div = 2'h0;
    int wcnt;
    int n_fail = 0;
    int checked = 0;

    // single slave, so its ready is the bus ready
    always_comb
    begin
        bus = drv;
        bus.hready = o_hreadyout;
    end

    initial
    begin
        forever #20 i_clk_sys = ~i_clk_sys;
    end

    // slow clock runs free at 8 system cycles a period, much faster than real to keep runs short
    always @(posedge i_clk_sys)
    begin
        lp_div <= lp_div + 2'h1;
        if (lp_div == 2'h3)
            i_lp_clk <= ~i_lp_clk;
    end

    sdc_deep_sleep_ctrl #(.SLOT_CYCLES(8)) u_sdc_deep_sleep_ctrl (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_ahb(bus),
        .o_hrdata(o_hrdata),
        .o_hreadyout(o_hreadyout),
        .o_hresp(o_hresp),
        .i_lp_clk(i_lp_clk),
        .i_system_wake_request(i_system_wake_request),
        .o_lp_clk_select(o_lp_clk_select),
        .o_low_power_wake_interrupt(o_low_power_wake_interrupt),
        .o_irq(o_irq),
        .o_rx_chain_head(o_rx_chain_head),
        .o_slot_counter_value(o_slot_counter_value),
        .o_counters_running(o_counters_running)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("Error %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ready is looked at mid-cycle, where it already holds the value the next edge samples
    task automatic rdy;
        int n;
        n = 0;
        @(negedge i_clk_sys);
        while (o_hreadyout !== 1'b1 && n < 50)
        begin
            @(negedge i_clk_sys);
            n++;
        end
        if (n == 50)
        begin
            n_fail++;
            conclude();
        end
        rd = o_hrdata;
        @(posedge i_clk_sys);
    endtask

    task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
        drv.hsel <= 1'b1;
        drv.haddr <= a;
        drv.hwrite <= w;
        drv.htrans <= 2'b10;
        drv.hsize <= 3'b010;
        rdy();
        drv.htrans <= 2'b00;
        drv.hwdata <= d;
        rdy();
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask

    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0000_0000);
        chk(rd, exp);
    endtask

    // waits for the clock select (or wake interrupt) to reach v; wcnt keeps the cycles taken
    task automatic wt(input logic use_irq, input logic v);
        wcnt = 0;
        @(negedge i_clk_sys);
        while ((use_irq ? o_low_power_wake_interrupt : o_lp_clk_select) !== v && wcnt < 3000)
        begin
            @(negedge i_clk_sys);
            wcnt++;
        end
        if (wcnt == 3000)
        begin
            n_fail++;
            conclude();
        end
        @(posedge i_clk_sys);
    endtask

    task automatic t_reset;
        rdchk(A_RXPTR, RST_WORD);
        rdchk(A_DSCTL, RST_WORD);
        rdchk(A_STIME, RST_WORD);
        rdchk(A_SDUR, RST_WORD);
        rdchk(A_WTIM, RST_WORD);
        rdchk(32'h4000_0100, 32'h0000_0000);
        chk(o_counters_running, 32'h0000_0001);
        wr(A_RXPTR, 32'hFFFF_FFFF);
        rdchk(A_RXPTR, 32'h0000_3FFF);
        chk(o_rx_chain_head, 32'h0000_3FFF);
        chk(o_hresp, 32'h0000_0000);
    endtask

    // timed sleep of 6 slow cycles, interrupt 3 ahead of expiry and released 1 ahead
    task automatic t_timed;
        wr(A_WTIM, {11'h004, 11'h003, 10'h001});
        wr(A_STIME, 32'h0000_0006);
        wr(A_IEN, 32'h0000_0000);
        wr(A_DSCTL, 32'h0000_0007);
        wt(1'b0, 1'b1);
        rdchk(A_DSCTL, 32'h0000_8007);
        wt(1'b1, 1'b1);
        wt(1'b1, 1'b0);
        chk(wcnt == 15, 32'h0000_0001);
        wt(1'b0, 1'b0);
        chk(wcnt == 7, 32'h0000_0001);
        rdchk(A_SDUR, 32'h0000_0006);
        rdchk(A_DSCTL, 32'h0000_0003);
        wr(A_DSCTL, 32'h0000_000B);
        rdchk(A_DSCTL, 32'h0000_0003);
        chk(o_counters_running, 32'h0000_0001);
        // events held masked, then unmasked, then cleared
        chk(o_irq, 32'h0000_0000);
        rdchk(A_ISTAT, 32'h0000_0007);
        wr(A_IEN, 32'h0000_0002);
        rdchk(A_IEN, 32'h0000_0002);
        chk(o_irq, 32'h0000_0001);
        wr(A_ICLR, 32'h0000_0007);
        rdchk(A_ISTAT, 32'h0000_0000);
        chk(o_irq, 32'h0000_0000);
    endtask

    // zero sleep time never expires; only the software request ends it
    task automatic t_soft;
        logic [26:0] s_live;
        logic [26:0] s_copy;
        wr(A_STIME, 32'h0000_0000);
        wr(A_DSCTL, 32'h0000_0007);
        wt(1'b0, 1'b1);
        repeat (200) @(posedge i_clk_sys);
        chk(o_lp_clk_select, 32'h0000_0001);
        chk(o_counters_running, 32'h0000_0000);
        // counters stand still in sleep, so the sampled copy must equal the live value
        @(negedge i_clk_sys);
        s_copy = o_slot_counter_value;
        @(posedge i_clk_sys);
        wr(A_SAMP, 32'h0000_0001);
        rdchk(A_SLOT, {5'h00, s_copy});
        // wake written with the request bit still set; the wake must clear it
        wr(A_DSCTL, 32'h0000_0017);
        wt(1'b0, 1'b0);
        rdchk(A_DSCTL, 32'h0000_0003);
        // resumed, the bench's 8-cycle slot gives ten slots in 80 cycles; the copy waits
        wr(A_DSCTL, 32'h0000_000B);
        @(negedge i_clk_sys);
        s_live = o_slot_counter_value;
        repeat (80) @(negedge i_clk_sys);
        chk(o_slot_counter_value, {5'h00, s_live + 27'h000_000A});
        @(posedge i_clk_sys);
        rdchk(A_SLOT, {5'h00, s_copy});
    endtask

    // blocked external request is ignored, unblocked it wakes after the hold time
    task automatic t_ext;
        wr(A_DSCTL, 32'h8000_0007);
        wt(1'b0, 1'b1);
        i_system_wake_request <= 1'b1;
        repeat (100) @(posedge i_clk_sys);
        chk(o_lp_clk_select, 32'h0000_0001);
        chk(o_low_power_wake_interrupt, 32'h0000_0000);
        wr(A_DSCTL, 32'h0000_0007);
        wt(1'b1, 1'b1);
        wt(1'b1, 1'b0);
        chk(wcnt >= 24 && wcnt <= 31, 32'h0000_0001);
        i_system_wake_request <= 1'b0;
        wt(1'b0, 1'b0);
        rdchk(A_DSCTL, 32'h0000_0003);
    endtask

    initial
    begin
        repeat (2) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        @(posedge i_clk_sys);
        t_reset();
        t_timed();
        t_soft();
        t_ext();
        conclude();
    end
endmodule // sdc_deep_sleep_ctrl_test
